/* verilog/ptpr_regs.sv */
`timescale 1ns/1ps
// What this block does
// RQ1 - A Sync frame leaving port 1 stores nanoseconds 15..0 of its egress time in the port 1 Sync low word.
// RQ2 - The port 1 Sync high word holds seconds 1..0 in bits 15..14 and nanoseconds 29..16 in bits 13..0.
// RQ3 - A Pdelay_Resp frame leaving port 1 stores its egress time split the same way into its own word pair.
// RQ4 - Port 2 stores in one shared pair the egress time of its last Pdelay_Req or Delay_Req, low word ns 15..0.
// RQ5 - That shared high word holds seconds 1..0 in bits 15..14 and nanoseconds 29..16 in bits 13..0.
// RQ6 - A 16-bit port 2 receive latency in ns is held, reset to 0x019F.
// RQ7 - A 16-bit port 2 transmit latency in ns is held, reset to 0x002D.
// RQ8 - The port 2 asymmetry is sign-magnitude, bit 15 set meaning negative, all bits reset to zero.
// RQ9 - Sync and Pdelay_Resp received on port 2 get the signed asymmetry added to their correction field.
// RQ10 - Delay_Req and Pdelay_Req sent on port 2 get the signed asymmetry subtracted from their correction field.
// RQ11 - Software programs and the block holds a 16-bit port 2 link delay in ns, reset to zero.
// RQ12 - Both words of a timestamp pair are updated together in one edge so a reader sees one timestamp.

module ptpr_regs (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ptpr_pkg::ptpr_host_req_t hostReq,
    output logic [15:0] hostRdata,
    input wire logic p1SyncTx,
    input wire logic p1RespTx,
    input wire logic p2ReqTx,
    input wire ptpr_pkg::ptpr_ts_t egressTs,
    input wire logic p2RxCorrValid,
    input wire logic p2RxCorrIsEvent,
    input wire logic [ptpr_pkg::CORR_W-1:0] p2RxCorrIn,
    output logic [ptpr_pkg::CORR_W-1:0] p2RxCorrOut,
    input wire logic p2TxCorrValid,
    input wire logic [ptpr_pkg::CORR_W-1:0] p2TxCorrIn,
    output logic [ptpr_pkg::CORR_W-1:0] p2TxCorrOut,
    output logic [15:0] p2RxLatency,
    output logic [15:0] p2TxLatency,
    output logic [15:0] p2LinkDelay
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] p1SyncLow_r, p1SyncHigh_r, p1RespLow_r, p1RespHigh_r;
    logic [15:0] rxLat_r, txLat_r, asym_r, linkDly_r, reqLow_r, reqHigh_r;
    logic [ptpr_pkg::CORR_W-1:0] rxCorr_r, txCorr_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire [15:0] tsLow = egressTs.ns[15:0];
    wire [15:0] tsHigh = {egressTs.sec, egressTs.ns[29:16]}; // [RQ2] [RQ5]
    wire wr = hostReq.wr;
    wire [11:0] a = hostReq.addr;
    wire wP1SL = wr && a == ptpr_pkg::OFF_P1_SYNC_LOW;
    wire wP1SH = wr && a == ptpr_pkg::OFF_P1_SYNC_HIGH;
    wire wP1RL = wr && a == ptpr_pkg::OFF_P1_RESP_LOW;
    wire wP1RH = wr && a == ptpr_pkg::OFF_P1_RESP_HIGH;
    wire wRx = wr && a == ptpr_pkg::OFF_P2_RX_LAT;
    wire wTx = wr && a == ptpr_pkg::OFF_P2_TX_LAT;
    wire wAsym = wr && a == ptpr_pkg::OFF_P2_ASYM;
    wire wLink = wr && a == ptpr_pkg::OFF_P2_LINK_DLY;
    wire wReqL = wr && a == ptpr_pkg::OFF_P2_REQ_LOW;
    wire wReqH = wr && a == ptpr_pkg::OFF_P2_REQ_HIGH;

    // Sign-magnitude asymmetry widened to a two's complement correction term.
    wire asymNeg = asym_r[ptpr_pkg::ASYM_SIGN_BIT]; // [RQ8]
    wire [ptpr_pkg::CORR_W-1:0] asymMag = {{(ptpr_pkg::CORR_W-15){1'b0}}, asym_r[14:0]};
    wire [ptpr_pkg::CORR_W-1:0] asymSigned = asymNeg ? (~asymMag + 1'b1) : asymMag; // [RQ8]
    wire [ptpr_pkg::CORR_W-1:0] rxCorrNxt = p2RxCorrIsEvent ? p2RxCorrIn + asymSigned : p2RxCorrIn; // [RQ9]
    wire [ptpr_pkg::CORR_W-1:0] txCorrNxt = p2TxCorrIn - asymSigned; // [RQ10]

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [15:0] rdMux;
    always_comb begin
        case (a)
            ptpr_pkg::OFF_P1_SYNC_LOW: rdMux = p1SyncLow_r;
            ptpr_pkg::OFF_P1_SYNC_HIGH: rdMux = p1SyncHigh_r;
            ptpr_pkg::OFF_P1_RESP_LOW: rdMux = p1RespLow_r;
            ptpr_pkg::OFF_P1_RESP_HIGH: rdMux = p1RespHigh_r;
            ptpr_pkg::OFF_P2_RX_LAT: rdMux = rxLat_r;
            ptpr_pkg::OFF_P2_TX_LAT: rdMux = txLat_r;
            ptpr_pkg::OFF_P2_ASYM: rdMux = asym_r;
            ptpr_pkg::OFF_P2_LINK_DLY: rdMux = linkDly_r;
            ptpr_pkg::OFF_P2_REQ_LOW: rdMux = reqLow_r;
            ptpr_pkg::OFF_P2_REQ_HIGH: rdMux = reqHigh_r;
            default: rdMux = ptpr_pkg::RST_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Timestamp capture
    // ------------------------------------------------------------
    // Capture beats a host write in the same cycle, so a fresh timestamp is never lost.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1SyncLow_r <= ptpr_pkg::RST_ZERO;
            p1SyncHigh_r <= ptpr_pkg::RST_ZERO;
        end else if (p1SyncTx) begin
            p1SyncLow_r <= tsLow; // [RQ1] [RQ12]
            p1SyncHigh_r <= tsHigh; // [RQ2] [RQ12]
        end else begin
            if (wP1SL) p1SyncLow_r <= hostReq.wdata;
            if (wP1SH) p1SyncHigh_r <= hostReq.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1RespLow_r <= ptpr_pkg::RST_ZERO;
            p1RespHigh_r <= ptpr_pkg::RST_ZERO;
        end else if (p1RespTx) begin
            p1RespLow_r <= tsLow; // [RQ3] [RQ12]
            p1RespHigh_r <= tsHigh; // [RQ3] [RQ12]
        end else begin
            if (wP1RL) p1RespLow_r <= hostReq.wdata;
            if (wP1RH) p1RespHigh_r <= hostReq.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reqLow_r <= ptpr_pkg::RST_ZERO;
            reqHigh_r <= ptpr_pkg::RST_ZERO;
        end else if (p2ReqTx) begin
            reqLow_r <= tsLow; // [RQ4] [RQ12]
            reqHigh_r <= tsHigh; // [RQ5] [RQ12]
        end else begin
            if (wReqL) reqLow_r <= hostReq.wdata;
            if (wReqH) reqHigh_r <= hostReq.wdata;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxLat_r <= ptpr_pkg::RST_RX_LAT; // [RQ6]
            txLat_r <= ptpr_pkg::RST_TX_LAT; // [RQ7]
            asym_r <= ptpr_pkg::RST_ZERO; // [RQ8]
            linkDly_r <= ptpr_pkg::RST_ZERO; // [RQ11]
        end else begin
            if (wRx) rxLat_r <= hostReq.wdata; // [RQ6]
            if (wTx) txLat_r <= hostReq.wdata; // [RQ7]
            if (wAsym) asym_r <= hostReq.wdata; // [RQ8]
            if (wLink) linkDly_r <= hostReq.wdata; // [RQ11]
        end
    end

    // ------------------------------------------------------------
    // Correction field path and read data
    // ------------------------------------------------------------
    // One register stage keeps the adder off the frame datapath's critical path.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxCorr_r <= '0;
            txCorr_r <= '0;
            hostRdata <= ptpr_pkg::RST_ZERO;
        end else begin
            if (p2RxCorrValid) rxCorr_r <= rxCorrNxt; // [RQ9]
            if (p2TxCorrValid) txCorr_r <= txCorrNxt; // [RQ10]
            if (hostReq.rd) hostRdata <= rdMux;
        end
    end

    assign p2RxCorrOut = rxCorr_r;
    assign p2TxCorrOut = txCorr_r;
    assign p2RxLatency = rxLat_r;
    assign p2TxLatency = txLat_r;
    assign p2LinkDelay = linkDly_r;

endmodule

/* verilog/ptpr_pkg.sv */
package ptpr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_P1_SYNC_LOW = 12'h064c;
    localparam logic [11:0] OFF_P1_SYNC_HIGH = 12'h064e;
    localparam logic [11:0] OFF_P1_RESP_LOW = 12'h0650;
    localparam logic [11:0] OFF_P1_RESP_HIGH = 12'h0652;
    localparam logic [11:0] OFF_P2_RX_LAT = 12'h0660;
    localparam logic [11:0] OFF_P2_TX_LAT = 12'h0662;
    localparam logic [11:0] OFF_P2_ASYM = 12'h0664;
    localparam logic [11:0] OFF_P2_LINK_DLY = 12'h0666;
    localparam logic [11:0] OFF_P2_REQ_LOW = 12'h0668;
    localparam logic [11:0] OFF_P2_REQ_HIGH = 12'h066a;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_RX_LAT = 16'h019f;
    localparam logic [15:0] RST_TX_LAT = 16'h002d;
    localparam int ASYM_SIGN_BIT = 15;
    localparam int HIGH_SEC_LSB = 14;
    localparam int CORR_W = 64;

    // ------------------------------------------------------------
    // Carried types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sec;
        logic [29:0] ns;
    } ptpr_ts_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } ptpr_host_req_t;

endpackage

/* sim/ptpr_regs_monitor.sv */
`timescale 1ns/1ps
module ptpr_regs_monitor (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ptpr_pkg::ptpr_host_req_t hostReq,
    input wire logic [15:0] hostRdata,
    input wire logic p1SyncTx,
    input wire ptpr_pkg::ptpr_ts_t egressTs,
    input wire logic p2RxCorrValid,
    input wire logic p2RxCorrIsEvent,
    input wire logic [63:0] p2RxCorrIn,
    input wire logic [63:0] p2RxCorrOut,
    input wire logic p2TxCorrValid,
    input wire logic [63:0] p2TxCorrIn,
    input wire logic [63:0] p2TxCorrOut,
    input wire logic [15:0] p2RxLatency,
    input wire logic [15:0] p2TxLatency,
    input wire logic [15:0] p2LinkDelay
);
    logic [15:0] asym_r;
    wire [11:0] a = hostReq.addr;
    wire w = hostReq.wr;
    wire quiet = !p1SyncTx && !w;
    wire [63:0] asymS = asym_r[15] ? -{49'h0, asym_r[14:0]} : {49'h0, asym_r[14:0]};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            asym_r <= 16'h0000;
        end else if (w && a == ptpr_pkg::OFF_P2_ASYM) begin
            asym_r <= hostReq.wdata;
        end
    end
    rx_event_add_a: assert property (p2RxCorrValid && p2RxCorrIsEvent
        |=> p2RxCorrOut == $past(p2RxCorrIn) + $past(asymS)) else $error("rx correction sum wrong");
    rx_pass_a: assert property (p2RxCorrValid && !p2RxCorrIsEvent
        |=> p2RxCorrOut == $past(p2RxCorrIn)) else $error("rx correction altered");
    tx_subtract_a: assert property (p2TxCorrValid
        |=> p2TxCorrOut == $past(p2TxCorrIn) - $past(asymS)) else $error("tx correction wrong");
    rx_latency_a: assert property (w && a == ptpr_pkg::OFF_P2_RX_LAT
        |=> p2RxLatency == $past(hostReq.wdata)) else $error("rx latency not written");
    tx_latency_a: assert property (w && a == ptpr_pkg::OFF_P2_TX_LAT
        |=> p2TxLatency == $past(hostReq.wdata)) else $error("tx latency not written");
    link_delay_a: assert property (w && a == ptpr_pkg::OFF_P2_LINK_DLY
        |=> p2LinkDelay == $past(hostReq.wdata)) else $error("link delay not written");
    sync_low_a: assert property (p1SyncTx ##1 quiet && hostReq.rd && a == ptpr_pkg::OFF_P1_SYNC_LOW
        |=> hostRdata == $past(egressTs.ns[15:0], 2)) else $error("sync low word wrong");
    sync_high_a: assert property (p1SyncTx ##1 quiet && a == ptpr_pkg::OFF_P1_SYNC_LOW ##1 quiet
        ##1 hostReq.rd && a == ptpr_pkg::OFF_P1_SYNC_HIGH
        |=> hostRdata == {$past(egressTs.sec, 4), $past(egressTs.ns[29:16], 4)}) else $error("sync high word wrong");
endmodule
bind ptpr_regs ptpr_regs_monitor ptpr_regs_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n), .hostReq(hostReq),
    .hostRdata(hostRdata), .p1SyncTx(p1SyncTx), .egressTs(egressTs), .p2RxCorrValid(p2RxCorrValid),
    .p2RxCorrIsEvent(p2RxCorrIsEvent), .p2RxCorrIn(p2RxCorrIn), .p2RxCorrOut(p2RxCorrOut),
    .p2TxCorrValid(p2TxCorrValid), .p2TxCorrIn(p2TxCorrIn), .p2TxCorrOut(p2TxCorrOut),
    .p2RxLatency(p2RxLatency), .p2TxLatency(p2TxLatency), .p2LinkDelay(p2LinkDelay));

/* sim/ptpr_link_partner.sv */
`timescale 1ns/1ps
// Time of day of the link; seconds and the upper nanosecond bits start non-zero so every timestamp field carries ones.
module ptpr_link_partner (
    input wire logic ref_clk,
    input wire logic reset_n,
    output ptpr_pkg::ptpr_ts_t tod_r
);
    wire wrap = tod_r.ns >= 30'h3b9a_c9ec;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tod_r <= {2'h3, 30'h1a5a_5a50};
        end else begin
            tod_r.ns <= wrap ? tod_r.ns - 30'h3b9a_c9ec : tod_r.ns + 30'h0000_0014;
            tod_r.sec <= tod_r.sec + {1'b0, wrap};
        end
    end
endmodule

/* sim/ptp_port_timestamp_delay_regs_tb_top.sv */
`timescale 1ns/1ps
module ptp_port_timestamp_delay_regs_tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    ptpr_pkg::ptpr_host_req_t hostReq = '0;
    logic p1SyncTx = 1'b0, p1RespTx = 1'b0, p2ReqTx = 1'b0;
    logic p2RxCorrValid = 1'b0, p2RxCorrIsEvent = 1'b0, p2TxCorrValid = 1'b0;
    logic [63:0] p2RxCorrIn = '0, p2TxCorrIn = '0, p2RxCorrOut, p2TxCorrOut;
    logic [15:0] hostRdata, p2RxLatency, p2TxLatency, p2LinkDelay;
    logic [15:0] asv[4] = '{16'h0005, 16'h8005, 16'h7fff, 16'hffff};
    ptpr_pkg::ptpr_ts_t tod;
    int mdl[int];
    int err_count = 0, check_count = 0, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    ptpr_link_partner ptpr_link_partner_i (.ref_clk(ref_clk), .reset_n(reset_n), .tod_r(tod));
    ptpr_regs ptpr_regs_i (.ref_clk(ref_clk), .reset_n(reset_n), .hostReq(hostReq), .hostRdata(hostRdata),
        .p1SyncTx(p1SyncTx), .p1RespTx(p1RespTx), .p2ReqTx(p2ReqTx), .egressTs(tod), .p2RxCorrValid(p2RxCorrValid),
        .p2RxCorrIsEvent(p2RxCorrIsEvent), .p2RxCorrIn(p2RxCorrIn), .p2RxCorrOut(p2RxCorrOut),
        .p2TxCorrValid(p2TxCorrValid), .p2TxCorrIn(p2TxCorrIn), .p2TxCorrOut(p2TxCorrOut),
        .p2RxLatency(p2RxLatency), .p2TxLatency(p2TxLatency), .p2LinkDelay(p2LinkDelay));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input int a, input logic [15:0] d);
        hostReq <= '{wr: w, rd: !w, addr: 12'(a), wdata: d};
        @(posedge ref_clk);
        hostReq <= '0;
        if (w && mdl.exists(a)) mdl[a] = d;
        @(posedge ref_clk);
        if (!w) chk("hostRdata", mdl.exists(a) ? mdl[a] : 0, hostRdata);
    endtask
    // A held pulse captures at every edge, so only the last capture may survive.
    task automatic cap(input int k, input int a, input int n);
        {p1SyncTx, p1RespTx, p2ReqTx} <= 3'(k);
        repeat (n) begin
            @(posedge ref_clk);
            mdl[a] = tod.ns[15:0];
            mdl[a + 2] = {tod.sec, tod.ns[29:16]};
        end
        {p1SyncTx, p1RespTx, p2ReqTx} <= 3'h0;
    endtask
    task automatic corr(input logic ev, input logic [63:0] x);
        longint s;
        s = mdl[12'h0664][15] ? -longint'(mdl[12'h0664][14:0]) : longint'(mdl[12'h0664][14:0]);
        p2RxCorrValid <= 1'b1;
        p2RxCorrIsEvent <= ev;
        p2RxCorrIn <= x;
        p2TxCorrValid <= 1'b1;
        p2TxCorrIn <= ~x;
        @(posedge ref_clk);
        p2RxCorrValid <= 1'b0;
        p2TxCorrValid <= 1'b0;
        @(posedge ref_clk);
        chk("p2RxCorrOut", ev ? x + s : x, p2RxCorrOut);
        chk("p2TxCorrOut", ~x - s, p2TxCorrOut);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hfe3b_4d3f));
        for (int a = 12'h064c; a <= 12'h066a; a += 2) if (a < 12'h0654 || a > 12'h065e) mdl[a] = 0;
        mdl[12'h0660] = 16'h019f;
        mdl[12'h0662] = 16'h002d;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int a = 12'h064c; a <= 12'h066a; a += 2) acc(0, a, 0);
        for (int a = 12'h064c; a <= 12'h066a; a += 2) acc(1, a, 16'($urandom));
        for (int a = 12'h064c; a <= 12'h066a; a += 2) acc(0, a, 0);
        chk("p2RxLatency", mdl[12'h0660], p2RxLatency);
        chk("p2TxLatency", mdl[12'h0662], p2TxLatency);
        chk("p2LinkDelay", mdl[12'h0666], p2LinkDelay);
        cap(2, 12'h0650, 3);
        @(posedge ref_clk);
        cap(1, 12'h0668, 2);
        @(posedge ref_clk);
        // A host write meets the capture pulse in one cycle; the capture has to win.
        hostReq <= '{wr: 1'b1, rd: 1'b0, addr: 12'h064e, wdata: 16'h5555};
        cap(4, 12'h064c, 1);
        for (int a = 12'h064c; a <= 12'h066a; a += 2) acc(0, a, 0);
        foreach (asv[i]) begin
            acc(1, 12'h0664, asv[i]);
            corr(1'b1, {$urandom, $urandom});
            corr(1'b0, {$urandom, $urandom});
        end
        conclude();
    end
endmodule
